// ### test/tbd_conv_model.sv
// Purpose: converter sequencer stand-in, one set per start
// Assumes: lat is at least 1
// Notes: done pulse lat+1 cycles after start
`timescale 1ns/100ps
module tbd_conv_model (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       set_start,
	input  wire logic [7:0] lat,
	output logic            set_done
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_sys) begin
		set_done <= !srst && cnt_q == 8'h_01;
		if (srst) cnt_q <= 8'h_00;
		else if (set_start) cnt_q <= lat;
		else if (cnt_q != 8'h_00) cnt_q <= cnt_q - 8'h_01;
	end
endmodule // tbd_conv_model

// ### test/tbd_pacer_checker.sv
// Purpose: port checks of the batch-delay scan pacer
// Assumes: bound into tbd_batch_pacer, single clock
// Notes: srst disables every property
`timescale 1ns/100ps
module tbd_pacer_checker
	import tbd_pkg::*;
#(
	parameter int MS_DIV = CYC_PER_MS
) (
	input wire logic              clk_sys,
	input wire logic              srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic              pen_touch,
	input wire logic              func_scan_req,
	input wire logic              set_done,
	input wire logic              set_start,
	input wire logic              scan_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_launch; $rose(scan_active); endsequence
	sequence s_cfg_rd; avs_read && !avs_waitrequest && avs_address == ADDR_CFG1; endsequence
	property p_ws; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
	a_ws: assert property (p_ws) else $error("no wait state");
	property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("late bus answer");
	property p_rsv; s_cfg_rd |-> avs_readdata[15:3] == 13'h_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_rst; $fell(srst) |-> !scan_active && !set_start && avs_readdata == '0; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_launch; s_launch |-> $past(pen_touch) && $past(func_scan_req); endproperty
	a_launch: assert property (p_launch) else $error("launch without touch");
	property p_first; s_launch |-> set_start; endproperty
	a_first: assert property (p_first) else $error("first set late");
	property p_pulse; set_start |=> !set_start; endproperty
	a_pulse: assert property (p_pulse) else $error("start too long");
	property p_act; set_start |-> scan_active; endproperty
	a_act: assert property (p_act) else $error("start while idle");
	property p_gap; set_done |=> !set_start; endproperty
	a_gap: assert property (p_gap) else $error("no wait after set");
	sequence s_stop_wr;
		avs_write && !avs_waitrequest && avs_address == ADDR_CTRL &&
			avs_writedata[CTRL_STOP_BIT];
	endsequence
	property p_stop; s_stop_wr |-> ##2 !scan_active; endproperty
	a_stop: assert property (p_stop) else $error("stop did not end scan");
endmodule // tbd_pacer_checker
bind tbd_batch_pacer tbd_pacer_checker #(.MS_DIV(MS_DIV)) i_chk (
	.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .pen_touch(pen_touch), .set_done(set_done),
	.func_scan_req(func_scan_req), .set_start(set_start), .scan_active(scan_active)
);

// ### test/touch_scan_batch_delay_bench.sv
// Purpose: self-checking bench of the scan pacer
// Assumes: ms divider shortened to DIV cycles
// Notes: reads checked at the accepting edge, set spacing on the falling edge
`timescale 1ns/100ps
module touch_scan_batch_delay_bench;
	import tbd_pkg::*;
	localparam int DIV = 10;
	logic clk_sys = 0, srst = 1, avs_read = 0, avs_write = 0, pen_touch = 0, func_scan_req = 0;
	logic [3:0]  avs_address = 4'h_0;
	logic [15:0] avs_writedata = 16'h_0000, avs_readdata, v, rv;
	logic        avs_waitrequest, set_done, set_start, scan_active, had = 0;
	logic [7:0]  lat = 8'h_04;
	int          fails = 0, total_checks = 0, starts = 0, cnt = 0;
	logic [15:0] exp_rd [$];
	int          exp_gap [$];
	tbd_batch_pacer #(.MS_DIV(DIV)) i_dut (.clk_sys(clk_sys), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pen_touch(pen_touch), .func_scan_req(func_scan_req),
		.set_done(set_done), .set_start(set_start), .scan_active(scan_active));
	tbd_conv_model i_conv (.clk_sys(clk_sys), .srst(srst), .set_start(set_start), .lat(lat),
		.set_done(set_done));
	initial forever #2 clk_sys = ~clk_sys;
	task close_out;
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task fail(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		int k;
		@(posedge clk_sys);
		{avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0) begin fail("bus hang"); close_out(); end
		{avs_write, avs_read} <= 2'b00;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 16'h_0000);
	endtask
	task wait_idle;
		int k;
		for (k = 0; k < 3000 && scan_active !== 1'b0; k++) @(negedge clk_sys);
		total_checks++;
		if (k == 3000) begin fail("scan never ends"); close_out(); end
	endtask
	// one scan of n sets; host mode needs go, stop ends it by command
	task run(input int c, input int n, input bit go, input bit stop);
		int g, k;
		g = DLY_MS[c] * DIV;
		if (lat > g) g = lat;
		repeat (n - 1) exp_gap.push_back(g);
		starts = 0;
		@(posedge clk_sys);
		{pen_touch, func_scan_req} <= 2'b11;
		if (go) begin
			repeat (20) @(negedge clk_sys);
			total_checks++;
			if (scan_active !== 1'b0) fail("host scan without go");
			bus(1'b1, ADDR_CTRL, 16'h_0002);
		end
		for (k = 0; k < 20000 && starts < n; k++) @(negedge clk_sys);
		if (starts < n) begin fail("pacing stalled"); close_out(); end
		if (stop) bus(1'b1, ADDR_CTRL, 16'h_0004);
		@(posedge clk_sys);
		if (!stop) {pen_touch, func_scan_req} <= 2'b00;
		wait_idle();
		@(posedge clk_sys);
		{pen_touch, func_scan_req} <= 2'b00;
	endtask
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			total_checks++;
			rv = exp_rd.pop_front();
			if (avs_readdata !== rv) fail("read data");
		end
	end
	always @(negedge clk_sys) begin
		if (scan_active !== 1'b1) had = 0;
		if (set_start === 1'b1) begin
			starts++;
			if (had) begin
				total_checks++;
				if (exp_gap.size() == 0) fail("extra set");
				else if (cnt < exp_gap[0] || cnt > exp_gap[0] + 8) fail("set spacing");
				if (exp_gap.size() != 0) exp_gap.pop_front();
			end
			had = 1;
			cnt = 0;
		end
		cnt++;
	end
	initial begin
		#300000;
		fail("run too long");
		close_out();
	end
	initial begin
		v = $urandom(60512);
		repeat (2) @(posedge clk_sys);
		srst <= 0;
		rd(ADDR_CFG1, CFG1_RESET);
		rd(ADDR_CTRL, CTRL_RESET);
		v = $urandom;
		bus(1'b1, ADDR_CFG1, v);
		rd(ADDR_CFG1, {13'h_0000, v[2:0]});
		bus(1'b1, 4'h_3, 16'h_ffff);
		rd(4'h_3, UNMAPPED_DATA);
		bus(1'b1, ADDR_CTRL, 16'h_0001);
		rd(ADDR_STAT, 16'h_0001);
		for (int c = 0; c < 8; c++) begin
			lat = 8'($urandom_range(3, 30));
			bus(1'b1, ADDR_CFG1, 16'(c));
			run(c, 3, 0, 0);
		end
		lat = 8'h_28;
		bus(1'b1, ADDR_CFG1, 16'h_0001);
		run(1, 3, 0, 0);
		// reset in mid-scan must drop the scan and the register
		bus(1'b1, ADDR_CFG1, 16'h_0003);
		{pen_touch, func_scan_req} <= 2'b11;
		repeat (30) @(posedge clk_sys);
		srst <= 1;
		repeat (2) @(posedge clk_sys);
		{srst, pen_touch, func_scan_req} <= 3'b000;
		@(negedge clk_sys);
		total_checks++;
		if (scan_active !== 1'b0) fail("reset kept scan");
		rd(ADDR_CFG1, CFG1_RESET);
		bus(1'b1, ADDR_CFG1, 16'h_0002);
		lat = 8'($urandom_range(3, 15));
		run(2, 3, 1, 0);
		run(2, 2, 1, 1);
		rd(ADDR_STAT, 16'h_0000);
		close_out();
	end
endmodule // touch_scan_batch_delay_bench

// ### verilog/tbd_batch_pacer.sv
// Purpose: batch time-delay scheduler for repeated touch coordinate scans
// Assumes: converter sequencer outside runs one sample set per set_start pulse
// Notes: registers over avalon-mm, waitrequest low one cycle after request
// Functional notes
// - 3-bit delay selection in low bits of register 0xD, reset zero.
// - selection sets wait before each sample-and-conversion scan cycle.
// - nonzero delay launches successive sample sets automatically in both modes.
// - self-initiated scan begins on pen touch without host command.
// - set done before delay end means waiting until delay ends.
// - at delay end with touch present, run next set and restart timer.
// - when set processing exceeds delay, processing time governs rate.
// - delay counting starts when touch launches the scan.
// - host scan paced by delay while original touch stays uninterrupted.
// - code zero gives no delay; rate set by processing alone.
// - codes 1,2,3 give 1, 2, 4 ms delays.
// - codes 4..7 give 10, 20, 40, 100 ms delays.
// - pacing ends on touch loss, stop command or any reset.
`timescale 1ns/100ps
module tbd_batch_pacer
	import tbd_pkg::*;
#(
	parameter int MS_DIV = CYC_PER_MS
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              pen_touch,
	input  wire logic              func_scan_req,
	input  wire logic              set_done,
	output logic                   set_start,
	output logic                   scan_active
);
	tbd_bus_req_type req;
	tbd_state_type   state_q;
	tbd_state_type   state_d;
	logic [SEL_W-1:0] batch_delay_select_q;
	logic             pen_scan_mode_bit_q;
	logic             host_go_q;
	logic             stop_q;
	logic             ack_q;
	logic [DATA_W-1:0] rdata_q;
	logic             set_start_q;
	logic             ms_tick;
	logic             delay_expired;
	logic             timer_load;

	assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata};

	// one wait cycle on every access keeps the read path registered
	wire bus_req  = req.rd || req.wr;
	wire take     = bus_req && !ack_q;
	assign avs_waitrequest = bus_req && !ack_q;
	// writes commit on the edge at which the master sees waitrequest low
	wire accept   = bus_req && ack_q;
	wire wr_cfg1  = accept && req.wr && (req.addr == ADDR_CFG1);
	wire wr_ctrl  = accept && req.wr && (req.addr == ADDR_CTRL);

	always_ff @(posedge clk_sys) begin
		if (srst)
			ack_q <= 1'b0;
		else
			ack_q <= take;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			batch_delay_select_q <= CFG1_RESET[SEL_W-1:0];
		else if (wr_cfg1)
			batch_delay_select_q <= req.wdata[SEL_W-1:0];
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			pen_scan_mode_bit_q <= CTRL_RESET[CTRL_PSM_BIT];
		else if (wr_ctrl)
			pen_scan_mode_bit_q <= req.wdata[CTRL_PSM_BIT];
	end

	// start and stop are self-clearing command pulses
	wire go_cmd   = wr_ctrl && req.wdata[CTRL_GO_BIT];
	wire stop_cmd = wr_ctrl && req.wdata[CTRL_STOP_BIT];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			host_go_q <= 1'b0;
			stop_q    <= 1'b0;
		end else begin
			host_go_q <= go_cmd;
			stop_q    <= stop_cmd;
		end
	end

	wire is_idle = (state_q == ST_IDLE);
	wire [DATA_W-1:0] stat_word = {11'h_000, pen_touch, state_q == ST_WAIT,
		state_q == ST_SCAN, !is_idle, pen_scan_mode_bit_q};
	wire [DATA_W-1:0] cfg1_word = {{(DATA_W-SEL_W){1'b0}}, batch_delay_select_q};
	wire [DATA_W-1:0] ctrl_word = {{(DATA_W-1){1'b0}}, pen_scan_mode_bit_q};
	wire [DATA_W-1:0] rd_mux =
		(req.addr == ADDR_CFG1) ? cfg1_word :
		(req.addr == ADDR_CTRL) ? ctrl_word :
		(req.addr == ADDR_STAT) ? stat_word : UNMAPPED_DATA;

	always_ff @(posedge clk_sys) begin
		if (srst)
			rdata_q <= '0;
		else if (take && req.rd)
			rdata_q <= rd_mux;
	end
	assign avs_readdata = rdata_q;

	// scan launch: self mode on touch, host mode on function command
	wire self_launch = pen_scan_mode_bit_q && pen_touch && func_scan_req;
	wire host_launch = !pen_scan_mode_bit_q && pen_touch && host_go_q &&
		func_scan_req;
	// a stop pulse also blocks a relaunch in the same cycle
	wire launch  = is_idle && !stop_q && (self_launch || host_launch);
	wire abort   = !pen_touch || stop_q;

	wire [MS_W-1:0] sel_ms = DLY_MS[batch_delay_select_q];

	// timer reloads each time a set starts so delay counts from launch
	assign timer_load = (state_d == ST_SCAN) && (state_q != ST_SCAN);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (launch)
					state_d = ST_SCAN;
			end
			ST_SCAN: begin
				if (stop_q)
					state_d = ST_IDLE;
				else if (set_done)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (abort)
					state_d = ST_IDLE;
				else if (delay_expired)
					state_d = ST_CHK;
			end
			ST_CHK: begin
				if (abort)
					state_d = ST_IDLE;
				else
					state_d = ST_SCAN;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			set_start_q <= 1'b0;
		else
			set_start_q <= timer_load;
	end
	assign set_start   = set_start_q;
	assign scan_active = !is_idle;

	tbd_ms_tick #(
		.DIV(MS_DIV)
	) u_tick (
		.clk_sys(clk_sys),
		.srst   (srst),
		.restart(timer_load),
		.tick   (ms_tick)
	);

	tbd_delay_timer u_timer (
		.clk_sys(clk_sys),
		.srst   (srst),
		.load   (timer_load),
		.load_ms(sel_ms),
		.ms_tick(ms_tick),
		.expired(delay_expired)
	);
endmodule // tbd_batch_pacer

// ### verilog/tbd_delay_timer.sv
// Purpose: batch-delay countdown in milliseconds
// Assumes: ms_tick is a one-cycle enable
// Notes: zero load means expired at once
`timescale 1ns/100ps
module tbd_delay_timer
	import tbd_pkg::*;
(
	input  wire logic            clk_sys,
	input  wire logic            srst,
	input  wire logic            load,
	input  wire logic [MS_W-1:0] load_ms,
	input  wire logic            ms_tick,
	output logic                 expired
);
	logic [MS_W-1:0] rem_q;

	always_ff @(posedge clk_sys) begin
		if (srst)
			rem_q <= '0;
		else if (load)
			rem_q <= load_ms;
		else if (ms_tick && rem_q != '0)
			rem_q <= rem_q - 1'b1;
	end

	assign expired = (rem_q == '0) && !load;
endmodule // tbd_delay_timer

// ### verilog/tbd_ms_tick.sv
// Purpose: divide system clock to a one-cycle millisecond enable
// Assumes: srst synchronous active high
// Notes: restart re-phases the divider so the first tick is a full ms away
`timescale 1ns/100ps
module tbd_ms_tick
	import tbd_pkg::*;
#(
	parameter int DIV = CYC_PER_MS
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic restart,
	output logic      tick
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt_q;
	wire           at_end = (cnt_q == CW'(DIV - 1));

	always_ff @(posedge clk_sys) begin
		if (srst || restart || at_end)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	assign tick = at_end && !restart;
endmodule // tbd_ms_tick

// ### verilog/tbd_pkg.sv
// Purpose: shared constants and types for the batch-delay scan pacer
// Assumes: 250 MHz system clock, avalon-mm register slave, word addressing
// Notes: delay table values are in whole milliseconds
package tbd_pkg;
	localparam int          CLK_HZ        = 250_000_000;
	localparam int          MS_PER_S      = 1000;
	localparam int          CYC_PER_MS    = CLK_HZ / MS_PER_S;
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 16;
	localparam int          SEL_W         = 3;
	localparam int          MS_W          = 7;
	// printed register index of the batch-delay register
	localparam logic [3:0]  ADDR_CFG1     = 4'h_d;
	// control register at a chosen index: pen-scan mode, start, stop
	localparam logic [3:0]  ADDR_CTRL     = 4'h_c;
	// status register at a chosen index
	localparam logic [3:0]  ADDR_STAT     = 4'h_b;
	localparam logic [15:0] CFG1_RESET    = 16'h_0000;
	localparam logic [15:0] CTRL_RESET    = 16'h_0000;
	localparam int          CTRL_PSM_BIT  = 0;
	localparam int          CTRL_GO_BIT   = 1;
	localparam int          CTRL_STOP_BIT = 2;
	localparam logic [15:0] UNMAPPED_DATA = 16'h_0000;
	// delay per selection code, milliseconds
	localparam logic [6:0]  DLY_MS [8] = '{7'h_00, 7'h_01, 7'h_02, 7'h_04,
		7'h_0a, 7'h_14, 7'h_28, 7'h_64};

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SCAN = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_CHK  = 4'b1000
	} tbd_state_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} tbd_bus_req_type;
endpackage
